// [core/dsau_top.sv]
// Dual data space access unit top level
`timescale 1ns/1ps
// Summary of operation
// - All writes use X bus; Y reads only
// - Bit reversal only for X writes
// - MAC reads X via 8/9, Y via 10/11
// - Accumulator write-back reaches whole space
// - Modulo on X pointer only; linear otherwise
// - Unimplemented address reads return zero
// - X pointer into Y returns zero
// - Y pointer into X returns zero
// - Sixteen-bit byte addresses, 32K words
// - Byte read selects byte by LSb
// - Shared word decode, separate byte strobes
// - Y path reads words only
// - Pointer step one byte, two word
// - Odd word access raises address trap
// - Misaligned write suppressed, trap after
// - Byte load changes only low byte
// - Sign extend and zero extend operations
// - Near direct field 13 bits wide
// - Move direct field covers 16 bits
// - Stack grows up, next free word
// - Call push clears upper PC byte
// - Exception push inserts status low byte
// - Push at limit allowed, next traps
// - Stack below 0x0800 raises trap
module dsau_top
  import dsau_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire dsau_req_s req,
  input wire logic [15:0] reg_old,
  input wire dsau_ext_e ext_op,
  input wire logic [15:0] stack_limit_reg,
  input wire logic [7:0] status_low_byte,
  input wire logic [15:0] pc_high_word,
  output dsau_rsp_s rsp,
  output logic [15:0] reg_result,
  output logic [15:0] stack_pointer_reg
);
`include "dsau_consts.svh"
  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic in_y(input logic [15:0] a);
    in_y = a >= `DSAU_Y_BASE && a <= `DSAU_Y_TOP;
  endfunction : in_y
  function automatic logic implemented(input logic [15:0] a);
    implemented = a <= `DSAU_MEM_TOP;
  endfunction : implemented

  // ****************************************
  // Storage, two byte lanes
  // ****************************************
  logic [7:0] mem_lo [`DSAU_MEM_WORDS];
  logic [7:0] mem_hi [`DSAU_MEM_WORDS];

  // ****************************************
  // Address decode
  // ****************************************
  logic [15:0] ea;
  logic [15:0] agu_next;
  logic [15:0] x_ptr;
  logic [15:0] y_ptr;
  logic is_push;
  logic is_pop;
  logic is_write;
  logic misaligned;
  logic wr_lo;
  logic wr_hi;
  logic [15:0] wdata;
  logic [10:0] widx;
  logic [10:0] yidx;
  logic limit_hit;
  logic below_sfr;
  assign is_push = req.op == DSAU_OP_PUSH || req.op == DSAU_OP_CALL || req.op == DSAU_OP_EXC;
  assign is_pop = req.op == DSAU_OP_POP;
  assign is_write = req.op == DSAU_OP_WRITE || is_push;
  // Ptr carries selected MAC X pointer; wdata carries the MAC Y pointer
  assign x_ptr = req.ptr;
  assign y_ptr = req.wdata;

  always_comb begin
    ea = req.ptr;
    if (req.direct && !req.direct_long) begin
      ea = {3'h0, req.ptr[12:0]};
    end
    if (req.direct && req.direct_long) begin
      ea = req.ptr;
    end
    if (is_pop) begin
      ea = stack_pointer_reg - `DSAU_STEP_WORD;
    end
    if (is_push) begin
      ea = stack_pointer_reg;
    end
  end

  assign misaligned = !req.byte_op && ea[0];
  assign widx = ea[11:1];
  assign yidx = y_ptr[11:1];

  always_comb begin
    wdata = req.wdata;
    if (req.op == DSAU_OP_CALL) begin
      wdata = {8'h00, pc_high_word[7:0]};
    end
    if (req.op == DSAU_OP_EXC) begin
      wdata = {status_low_byte, pc_high_word[7:0]};
    end
  end

  assign wr_lo = is_write && !misaligned && implemented(ea) && (!req.byte_op || !ea[0]);
  assign wr_hi = is_write && !misaligned && implemented(ea) && (!req.byte_op || ea[0]);

  assign limit_hit = is_push && stack_pointer_reg > stack_limit_reg;
  // underflow below SFR boundary
  // Pointer itself checked too, so a pop that wraps past zero still traps
  assign below_sfr = (is_push || is_pop) &&
                     (ea < `DSAU_SFR_TOP || stack_pointer_reg < `DSAU_SFR_TOP);

  dsau_agu u_agu (
    .ptr(req.ptr),
    .byte_op(req.byte_op),
    .modulo_en(req.modulo_en),
    .bit_rev(req.bit_rev && is_write),
    .modulo_start(req.modulo_start),
    .modulo_end(req.modulo_end),
    .next_ptr(agu_next)
  );

  // ****************************************
  // Write port
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (clk_en && req_valid && wr_lo) begin
      mem_lo[widx] <= wdata[7:0];
    end
    if (clk_en && req_valid && wr_hi) begin
      mem_hi[widx] <= req.byte_op ? wdata[7:0] : wdata[15:8];
    end
  end

  // ****************************************
  // Read paths
  // ****************************************
  logic [15:0] x_word;
  logic [15:0] next_x;
  logic [15:0] next_y;
  logic [15:0] next_reg;
  assign x_word = {mem_hi[widx], mem_lo[widx]};
  always_comb begin
    next_x = `DSAU_ZERO_WORD;
    next_y = `DSAU_ZERO_WORD;
    if (implemented(ea)) begin
      next_x = req.byte_op ? {8'h00, ea[0] ? x_word[15:8] : x_word[7:0]} : x_word;
    end
    if (req.op == DSAU_OP_MAC) begin
      next_x = (in_y(x_ptr) || !implemented(x_ptr)) ? `DSAU_ZERO_WORD :
               {mem_hi[x_ptr[11:1]], mem_lo[x_ptr[11:1]]};
      next_y = in_y(y_ptr) ? {mem_hi[yidx], mem_lo[yidx]} : `DSAU_ZERO_WORD;
    end
  end

  always_comb begin
    next_reg = reg_old;
    if (req.op == DSAU_OP_READ && req.byte_op) begin
      next_reg = {reg_old[15:8], next_x[7:0]};
    end else if (req.op == DSAU_OP_READ || is_pop) begin
      next_reg = next_x;
    end
    case (ext_op)
      DSAU_EXT_SIGN: next_reg = {{8{reg_old[7]}}, reg_old[7:0]};
      DSAU_EXT_ZERO: next_reg = {8'h00, reg_old[7:0]};
      default: next_reg = next_reg;
    endcase
  end

  // ****************************************
  // Response registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp <= '0;
      reg_result <= `DSAU_ZERO_WORD;
    end else if (clk_en) begin
      rsp.valid <= req_valid;
      rsp.xdata <= next_x;
      rsp.ydata <= next_y;
      rsp.next_ptr <= req.post_inc ? agu_next : req.ptr;
      rsp.addr_trap <= req_valid && misaligned;
      rsp.stack_trap <= req_valid && (limit_hit || below_sfr);
      reg_result <= req_valid ? next_reg : reg_result;
    end
  end

  // ****************************************
  // Stack pointer
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_pointer_reg <= `DSAU_SP_RESET;
    end else if (clk_en && req_valid) begin
      if (is_push) begin
        stack_pointer_reg <= stack_pointer_reg + `DSAU_STEP_WORD;
      end else if (is_pop) begin
        stack_pointer_reg <= stack_pointer_reg - `DSAU_STEP_WORD;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_trap_odd;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && req_valid && !req.byte_op && req.op == DSAU_OP_WRITE && ea[0]
      |=> rsp.addr_trap;
  endproperty
  a_trap_odd: assert property (p_trap_odd) else $error("odd word no trap");
  property p_push_step;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && req_valid && is_push |=> stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002;
  endproperty
  a_push_step: assert property (p_push_step) else $error("push step wrong");
  property p_pop_step;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && req_valid && is_pop |=> stack_pointer_reg == $past(stack_pointer_reg) - 16'h0002;
  endproperty
  a_pop_step: assert property (p_pop_step) else $error("pop step wrong");
  property p_unimpl_zero;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && req.op == DSAU_OP_READ && ea > 16'h0fff |=> rsp.xdata == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimpl not zero");
  property p_x_into_y;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && req.op == DSAU_OP_MAC && in_y(x_ptr) |=> rsp.xdata == 16'h0000;
  endproperty
  a_x_into_y: assert property (p_x_into_y) else $error("X ptr in Y not zero");
  property p_y_into_x;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && req.op == DSAU_OP_MAC && !in_y(y_ptr) |=> rsp.ydata == 16'h0000;
  endproperty
  a_y_into_x: assert property (p_y_into_x) else $error("Y ptr in X not zero");
  property p_limit_eq;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && req_valid && is_push && stack_pointer_reg == stack_limit_reg
      && stack_pointer_reg >= 16'h0800 |=> !rsp.stack_trap;
  endproperty
  a_limit_eq: assert property (p_limit_eq) else $error("trap at limit");
  property p_byte_keep;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && req_valid && req.op == DSAU_OP_READ && req.byte_op && ext_op == DSAU_EXT_NONE
      |=> reg_result[15:8] == $past(reg_old[15:8]);
  endproperty
  a_byte_keep: assert property (p_byte_keep) else $error("byte load hit upper");
  property p_sfr;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && req_valid && is_pop && stack_pointer_reg < 16'h0802 |=> rsp.stack_trap;
  endproperty
  a_sfr: assert property (p_sfr) else $error("underflow no trap");
  // Frame steps: request taken, stored word (upper byte only for a call) checked next cycle
  sequence s_push_taken;
    clk_en && req_valid && req.op == DSAU_OP_PUSH && implemented(ea);
  endsequence
  sequence s_call_taken;
    clk_en && req_valid && req.op == DSAU_OP_CALL && implemented(ea);
  endsequence
  sequence s_exc_taken;
    clk_en && req_valid && req.op == DSAU_OP_EXC && implemented(ea);
  endsequence
  property p_push_write;
    @(posedge core_clk) disable iff (!rst_n)
    s_push_taken |=> {mem_hi[$past(widx)], mem_lo[$past(widx)]} == $past(req.wdata);
  endproperty
  a_push_write: assert property (p_push_write) else $error("push data lost");
  property p_call_frame;
    @(posedge core_clk) disable iff (!rst_n)
    s_call_taken |=> mem_hi[$past(widx)] == 8'h00;
  endproperty
  a_call_frame: assert property (p_call_frame) else $error("call upper byte set");
  property p_exc_frame;
    @(posedge core_clk) disable iff (!rst_n)
    s_exc_taken |=> mem_hi[$past(widx)] == $past(status_low_byte)
      && mem_lo[$past(widx)] == $past(pc_high_word[7:0]);
  endproperty
  a_exc_frame: assert property (p_exc_frame) else $error("exception frame wrong");
  property p_mis_write;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && req_valid && is_write && misaligned
      |=> {mem_hi[$past(widx)], mem_lo[$past(widx)]} == $past(x_word);
  endproperty
  a_mis_write: assert property (p_mis_write) else $error("odd write stored");
  property p_byte_upper;
    @(posedge core_clk) disable iff (!rst_n)
    clk_en && req_valid && req.op == DSAU_OP_READ && req.byte_op |=> rsp.xdata[15:8] == 8'h00;
  endproperty
  a_byte_upper: assert property (p_byte_upper) else $error("byte read upper set");
  // Clock enable low must freeze the stack pointer and the response
  property p_freeze;
    @(posedge core_clk) disable iff (!rst_n)
    !clk_en |=> stack_pointer_reg == $past(stack_pointer_reg) && rsp == $past(rsp);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule : dsau_top

// [core/dsau_consts.svh]
// Constants of the dual data space access unit
`ifndef DSAU_CONSTS_SVH
`define DSAU_CONSTS_SVH
`define DSAU_NEAR_TOP 16'h1fff
`define DSAU_SFR_TOP 16'h0800
`define DSAU_Y_BASE 16'h0800
`define DSAU_Y_TOP 16'h0bff
`define DSAU_MEM_TOP 16'h0fff
`define DSAU_SP_RESET 16'h0800
`define DSAU_LIM_RESET 16'h0000
`define DSAU_ZERO_WORD 16'h0000
`define DSAU_STEP_BYTE 16'h0001
`define DSAU_STEP_WORD 16'h0002
`define DSAU_MEM_WORDS 2048
`endif

// [core/dsau_pkg.sv]
// Types of the dual data space access unit
package dsau_pkg;
  typedef enum logic [2:0] {
    DSAU_OP_NONE, DSAU_OP_READ, DSAU_OP_WRITE, DSAU_OP_MAC,
    DSAU_OP_PUSH, DSAU_OP_POP, DSAU_OP_CALL, DSAU_OP_EXC
  } dsau_op_e;
  typedef enum logic [1:0] {
    DSAU_EXT_NONE, DSAU_EXT_SIGN, DSAU_EXT_ZERO
  } dsau_ext_e;
  typedef struct packed {
    dsau_op_e op;
    logic byte_op;
    logic bit_rev;
    logic direct;
    logic direct_long;
    logic post_inc;
    logic [1:0] x_sel;
    logic [1:0] y_sel;
    logic [15:0] ptr;
    logic [15:0] wdata;
    logic [15:0] modulo_start;
    logic [15:0] modulo_end;
    logic modulo_en;
  } dsau_req_s;
  typedef struct packed {
    logic valid;
    logic [15:0] xdata;
    logic [15:0] ydata;
    logic [15:0] next_ptr;
    logic addr_trap;
    logic stack_trap;
  } dsau_rsp_s;
endpackage : dsau_pkg

// [core/dsau_agu.sv]
// Address generation unit with modulo and bit-reversed updates
`timescale 1ns/1ps
module dsau_agu
  import dsau_pkg::*;
(
  input wire logic [15:0] ptr,
  input wire logic byte_op,
  input wire logic modulo_en,
  input wire logic bit_rev,
  input wire logic [15:0] modulo_start,
  input wire logic [15:0] modulo_end,
  output logic [15:0] next_ptr
);
`include "dsau_consts.svh"
  logic [15:0] step;
  logic [15:0] sum;
  // Mirror of a pointer, used on both sides of the reversed-carry add
  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      rev16[i] = v[15 - i];
    end
  endfunction : rev16
  assign step = byte_op ? `DSAU_STEP_BYTE : `DSAU_STEP_WORD;
  assign sum = ptr + step;
  always_comb begin
    next_ptr = sum;
    if (bit_rev) begin
      next_ptr = rev16(rev16(ptr) + rev16(step));
    end else if (modulo_en && ptr >= modulo_end) begin
      next_ptr = modulo_start;
    end
  end
endmodule : dsau_agu

// [sim/dsau_pipe_model.sv]
// Execution pipeline model that issues requests to the access unit
`timescale 1ns/1ps
module dsau_pipe_model
  import dsau_pkg::*;
(
  input wire logic core_clk,
  input wire dsau_rsp_s rsp,
  output logic req_valid,
  output dsau_req_s req
);
  // ****************
  // Request issue
  // ****************
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // Request held through the taking edge; answer waited for a few cycles only
  // Mode bits: direct, long direct, bit reversal, modulo over 0x0100 to 0x0104
  task automatic issue(input dsau_op_e op, input logic byte_op, input logic [15:0] ptr,
                       input logic [15:0] wdata, input logic [3:0] mode,
                       output dsau_rsp_s got, output logic ok);
    int n;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= '{op: op, byte_op: byte_op, direct: mode[0], direct_long: mode[1],
             bit_rev: mode[2], modulo_en: mode[3], modulo_start: 16'h0100,
             modulo_end: 16'h0104, post_inc: 1'b1, ptr: ptr, wdata: wdata, default: '0};
    @(posedge core_clk);
    req_valid <= 1'b0;
    ok = 1'b0;
    got = '0;
    for (n = 0; n < 4 && ok == 1'b0; n++) begin
      #1;
      if (rsp.valid === 1'b1) begin
        ok = 1'b1;
        got = rsp;
      end else begin
        @(posedge core_clk);
      end
    end
  endtask : issue
endmodule : dsau_pipe_model

// [sim/tb_top.sv]
// Self-checking bench of the dual data space access unit
`timescale 1ns/1ps
module tb_top;
  import dsau_pkg::*;
  logic core_clk, reset_n, req_valid, ok, clk_en;
  logic [3:0] mode_q;
  dsau_req_s req;
  dsau_rsp_s rsp, got;
  dsau_ext_e ext_op;
  logic [15:0] reg_old, stack_limit_reg, pc_high_word, reg_result, stack_pointer_reg;
  logic [7:0] status_low_byte;
  int errors, check_count;
  dsau_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .reg_old(reg_old), .ext_op(ext_op),
    .stack_limit_reg(stack_limit_reg), .status_low_byte(status_low_byte),
    .pc_high_word(pc_high_word), .rsp(rsp), .reg_result(reg_result),
    .stack_pointer_reg(stack_pointer_reg));
  dsau_pipe_model i_pipe (.core_clk(core_clk), .rsp(rsp), .req_valid(req_valid), .req(req));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic go(input dsau_op_e op, input logic b, input logic [15:0] p,
                    input logic [15:0] w);
    i_pipe.issue(op, b, p, w, mode_q, got, ok);
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch answer expected 1 seen 0");
      stop_test();
    end
  endtask : go
  task automatic do_reset;
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : do_reset
  // ****************
  // Scenarios
  // ****************
  task automatic t_mem;
    reg_old <= 16'h5a5a;
    go(DSAU_OP_WRITE, 1'b0, 16'h0100, 16'h1234);
    chk("next_ptr word", got.next_ptr, 16'h0102);
    go(DSAU_OP_WRITE, 1'b1, 16'h0101, 16'h00ab);
    go(DSAU_OP_READ, 1'b0, 16'h0100, 16'h0000);
    chk("lane write", got.xdata, 16'hab34);
    go(DSAU_OP_READ, 1'b1, 16'h0101, 16'h0000);
    chk("byte read", got.xdata, 16'h00ab);
    chk("next_ptr byte", got.next_ptr, 16'h0102);
    chk("byte load", reg_result, 16'h5aab);
    go(DSAU_OP_WRITE, 1'b0, 16'h0bfe, 16'h7777);
    go(DSAU_OP_READ, 1'b0, 16'h0bfe, 16'h0000);
    chk("linear y", got.xdata, 16'h7777);
    $display("test mem done");
  endtask : t_mem
  task automatic t_mac;
    go(DSAU_OP_MAC, 1'b0, 16'h0100, 16'h0bfe);
    chk("mac x", got.xdata, 16'hab34);
    chk("mac y", got.ydata, 16'h7777);
    go(DSAU_OP_MAC, 1'b0, 16'h0bfe, 16'h0100);
    chk("x ptr in y", got.xdata, 16'h0000);
    chk("y ptr in x", got.ydata, 16'h0000);
    $display("test mac done");
  endtask : t_mac
  task automatic t_bad;
    go(DSAU_OP_READ, 1'b0, 16'h2000, 16'h0000);
    chk("unimplemented", got.xdata, 16'h0000);
    go(DSAU_OP_WRITE, 1'b0, 16'h0101, 16'hffff);
    chk("odd write trap", 16'(got.addr_trap), 16'h0001);
    go(DSAU_OP_READ, 1'b0, 16'h0101, 16'h0000);
    chk("odd read trap", 16'(got.addr_trap), 16'h0001);
    go(DSAU_OP_READ, 1'b0, 16'h0100, 16'h0000);
    chk("write dropped", got.xdata, 16'hab34);
    chk("even no trap", 16'(got.addr_trap), 16'h0000);
    $display("test bad done");
  endtask : t_bad
  task automatic t_addr;
    mode_q = 4'h1;
    go(DSAU_OP_READ, 1'b0, 16'he100, 16'h0000);
    chk("near direct", got.xdata, 16'hab34);
    mode_q = 4'h3;
    go(DSAU_OP_READ, 1'b0, 16'he100, 16'h0000);
    chk("long direct", got.xdata, 16'h0000);
    mode_q = 4'h4;
    go(DSAU_OP_WRITE, 1'b0, 16'h0102, 16'h0000);
    chk("reversed step", got.next_ptr, 16'h0101);
    go(DSAU_OP_READ, 1'b0, 16'h0102, 16'h0000);
    chk("read step linear", got.next_ptr, 16'h0104);
    mode_q = 4'h8;
    go(DSAU_OP_READ, 1'b0, 16'h0104, 16'h0000);
    chk("modulo wrap", got.next_ptr, 16'h0100);
    mode_q = 4'h0;
    $display("test addr done");
  endtask : t_addr
  task automatic t_hold;
    @(posedge core_clk);
    clk_en <= 1'b0;
    i_pipe.issue(DSAU_OP_PUSH, 1'b0, 16'h0000, 16'h5555, 4'h0, got, ok);
    clk_en <= 1'b1;
    #1;
    chk("frozen answer", 16'(ok), 16'h0000);
    chk("frozen sp", stack_pointer_reg, 16'h0800);
    $display("test hold done");
  endtask : t_hold
  task automatic t_ext;
    @(posedge core_clk);
    reg_old <= 16'h0080;
    ext_op <= DSAU_EXT_SIGN;
    go(DSAU_OP_NONE, 1'b0, 16'h0000, 16'h0000);
    chk("sign extend", reg_result, 16'hff80);
    @(posedge core_clk);
    reg_old <= 16'h1234;
    ext_op <= DSAU_EXT_ZERO;
    go(DSAU_OP_NONE, 1'b0, 16'h0000, 16'h0000);
    chk("zero extend", reg_result, 16'h0034);
    @(posedge core_clk);
    ext_op <= DSAU_EXT_NONE;
    $display("test ext done");
  endtask : t_ext
  task automatic t_stack;
    chk("sp reset", stack_pointer_reg, 16'h0800);
    go(DSAU_OP_PUSH, 1'b0, 16'h0000, 16'h1111);
    chk("sp push", stack_pointer_reg, 16'h0802);
    go(DSAU_OP_CALL, 1'b0, 16'h0000, 16'h0000);
    go(DSAU_OP_EXC, 1'b0, 16'h0000, 16'h0000);
    go(DSAU_OP_POP, 1'b0, 16'h0000, 16'h0000);
    chk("exception frame", got.xdata, 16'h3cc3);
    go(DSAU_OP_POP, 1'b0, 16'h0000, 16'h0000);
    chk("call frame", got.xdata, 16'h00c3);
    go(DSAU_OP_POP, 1'b0, 16'h0000, 16'h0000);
    chk("pop data", got.xdata, 16'h1111);
    chk("sp pop", stack_pointer_reg, 16'h0800);
    @(posedge core_clk);
    stack_limit_reg <= 16'h0802;
    go(DSAU_OP_PUSH, 1'b0, 16'h0000, 16'h2222);
    go(DSAU_OP_PUSH, 1'b0, 16'h0000, 16'h3333);
    chk("push at limit", 16'(got.stack_trap), 16'h0000);
    go(DSAU_OP_PUSH, 1'b0, 16'h0000, 16'h4444);
    chk("push past limit", 16'(got.stack_trap), 16'h0001);
    do_reset();
    go(DSAU_OP_POP, 1'b0, 16'h0000, 16'h0000);
    chk("below floor", 16'(got.stack_trap), 16'h0001);
    $display("test stack done");
  endtask : t_stack
  initial begin
    errors = 0;
    check_count = 0;
    reset_n = 1'b0;
    reg_old = 16'h0000;
    ext_op = DSAU_EXT_NONE;
    stack_limit_reg = 16'hfffe;
    status_low_byte = 8'h3c;
    pc_high_word = 16'ha5c3;
    clk_en = 1'b1;
    mode_q = 4'h0;
    do_reset();
    t_mem();
    t_mac();
    t_bad();
    t_addr();
    t_ext();
    t_hold();
    t_stack();
    stop_test();
  end
endmodule : tb_top
